/* File: ppcu_config_bank.sv */
// Unlock-protected configuration register bank for the parallel port
//
// What this block does
// - Two back-to-back 55h select writes unlock configuration.
// - Any other write between keys aborts unlock.
// - Select index picks register seen at data port.
// - AAh at select port leaves configuration mode.
// - Config registers reset only at power-up.
// - Select register write-only, accepted only when unlocked.
// - Base register at index 01h, default 9Fh.
// - Base bit 3 set forces compatibility personality.
// - Base bits 1:0 choose port address or disable.
// - Mode register at index 04h, default 00h.
// - Mode bits 1:0 pick standard, EPP, ECP, both.
// - Compatibility bit overrides mode register bits.
// - Extended control 000 standard; 100 EPP only in ECP+EPP mode (ECP in ECP-only mode).
// - FIFO threshold register at index 0Ah, default 00h.
//
// Design decision made here: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module ppcu_config_bank
  import ppcu_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        power_on_resetn,
  input  wire logic [31:0] addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [7:0]  rdata,
  input  wire logic [2:0]  ext_ctl_mode,
  output logic             config_mode,
  output logic             port_enable,
  output logic      [31:0] port_base_addr,
  output var ppcu_opmode_t   port_opmode,
  output var ppcu_protocol_t active_protocol,
  output logic      [7:0]  fifo_threshold
);

  logic       key_seen_q;
  logic       cfg_mode_q;
  logic [7:0] index_q;
  logic [7:0] base_reg_q;
  logic [7:0] mode_reg_q;
  logic [7:0] fifo_reg_q;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic       sel_wr;
  logic       data_wr;
  logic       data_rd;

  assign sel_wr  = wr && (addr == PPCU_SELECT_ADDR);
  assign data_wr = wr && (addr == PPCU_DATA_ADDR) && cfg_mode_q;
  assign data_rd = rd && (addr == PPCU_DATA_ADDR) && cfg_mode_q;

  // Unlock detector: only an adjacent pair of key writes counts
  always_ff @(posedge clk) begin
    if (!resetn) begin
      key_seen_q <= 1'b0;
    end else if (wr) begin
      key_seen_q <= sel_wr && (wdata == PPCU_UNLOCK_KEY) && !key_seen_q && !cfg_mode_q;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      cfg_mode_q <= 1'b0;
    end else if (sel_wr && cfg_mode_q && (wdata == PPCU_EXIT_KEY)) begin
      cfg_mode_q <= 1'b0;
    end else if (sel_wr && key_seen_q && (wdata == PPCU_UNLOCK_KEY)) begin
      cfg_mode_q <= 1'b1;
    end
  end

  // The exit key never lands in the select register; a 55h written while unlocked does
  always_ff @(posedge clk) begin
    if (!resetn) begin
      index_q <= PPCU_IDX_RESET;
    end else if (!cfg_mode_q) begin
      index_q <= PPCU_IDX_RESET;
    end else if (sel_wr && (wdata != PPCU_EXIT_KEY)) begin
      index_q <= wdata;
    end
  end

  // Only the power-up reset touches the bank; resetn is ignored here
  always_ff @(posedge clk) begin
    if (!power_on_resetn) begin
      base_reg_q <= PPCU_BASE_RESET;
      mode_reg_q <= PPCU_MODE_RESET;
      fifo_reg_q <= PPCU_FIFO_RESET;
    end else if (data_wr) begin
      case (index_q)
        PPCU_IDX_BASE: base_reg_q <= wdata;
        PPCU_IDX_MODE: mode_reg_q <= wdata;
        PPCU_IDX_FIFO: fifo_reg_q <= wdata;
        default: ;
      endcase
    end
  end

  always_comb begin
    rdata_d = 8'h00;
    if (data_rd) begin
      case (index_q)
        PPCU_IDX_BASE: rdata_d = base_reg_q;
        PPCU_IDX_MODE: rdata_d = mode_reg_q;
        PPCU_IDX_FIFO: rdata_d = fifo_reg_q;
        default:       rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign rdata          = rdata_q;
  assign config_mode    = cfg_mode_q;
  assign fifo_threshold = fifo_reg_q;

  always_comb begin
    case (base_reg_q[1:0])
      2'h1:    port_base_addr = PPCU_BASE_ALT1;
      2'h2:    port_base_addr = PPCU_BASE_ALT2;
      2'h3:    port_base_addr = PPCU_BASE_DEFAULT;
      default: port_base_addr = PPCU_BASE_NONE;
    endcase
  end
  assign port_enable = (base_reg_q[1:0] != 2'h0);

  always_comb begin
    if (base_reg_q[PPCU_COMPAT_BIT]) begin
      port_opmode = PPCU_OP_COMPAT;
    end else begin
      case (mode_reg_q[1:0])
        2'h0:    port_opmode = PPCU_OP_STD;
        2'h1:    port_opmode = PPCU_OP_EPP_STD;
        2'h2:    port_opmode = PPCU_OP_ECP;
        default: port_opmode = PPCU_OP_ECP_EPP;
      endcase
    end
  end

  // Extended control field only matters in ECP-capable settings
  always_comb begin
    case (port_opmode)
      PPCU_OP_COMPAT:  active_protocol = PPCU_PROT_COMPAT;
      PPCU_OP_STD:     active_protocol = PPCU_PROT_STD;
      PPCU_OP_EPP_STD: active_protocol = PPCU_PROT_EPP;
      PPCU_OP_ECP, PPCU_OP_ECP_EPP: begin
        if (ext_ctl_mode == PPCU_XCTL_STD) begin
          active_protocol = PPCU_PROT_STD;
        end else if (ext_ctl_mode == PPCU_XCTL_EPP && port_opmode == PPCU_OP_ECP_EPP) begin
          active_protocol = PPCU_PROT_EPP;
        end else begin
          active_protocol = PPCU_PROT_ECP;
        end
      end
      default: active_protocol = PPCU_PROT_COMPAT;
    endcase
  end

endmodule
`default_nettype wire

/* File: ppcu_config_bank_props.sv */
// Checker for the config unlock bank
`timescale 1ns/100ps
`default_nettype none
module ppcu_config_bank_props import ppcu_pkg::*; (
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic [31:0] addr,
  input wire logic [7:0]  wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [7:0]  rdata,
  input wire logic        config_mode
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  wire s = wr && addr == PPCU_SELECT_ADDR;
  wire k = s && wdata == PPCU_UNLOCK_KEY;
  wire x = s && wdata == PPCU_EXIT_KEY;
  property p_ul; k ##1 k |=> config_mode; endproperty
  a_ul: assert property (p_ul) else $error("no entry");
  property p_nk; !config_mode && !k |=> !config_mode; endproperty
  a_nk: assert property (p_nk) else $error("entry");
  property p_dw; wr && !s |=> $stable(config_mode); endproperty
  a_dw: assert property (p_dw) else $error("flip");
  property p_nw; !wr |=> $stable(config_mode); endproperty
  a_nw: assert property (p_nw) else $error("flip");
  property p_ex; x |=> !config_mode; endproperty
  a_ex: assert property (p_ex) else $error("no exit");
  property p_st; config_mode && !x |=> config_mode; endproperty
  a_st: assert property (p_st) else $error("exit");
  property p_id; !rd |=> !rdata; endproperty
  a_id: assert property (p_id) else $error("data");
  property p_lr; rd && !config_mode |=> !rdata; endproperty
  a_lr: assert property (p_lr) else $error("locked");
endmodule
bind ppcu_config_bank ppcu_config_bank_props i_ppcu_config_bank_props (.*);
`default_nettype wire

/* File: ppcu_config_bank_tb.sv */
// Bench for the config unlock bank
`timescale 1ns/100ps
`default_nettype none
module ppcu_config_bank_tb import ppcu_pkg::*;;
  localparam logic [31:0] SA = PPCU_SELECT_ADDR, DA = PPCU_DATA_ADDR;
  logic clk = 1'h0, resetn, power_on_resetn, wr, rd, config_mode, port_enable;
  logic [31:0] addr, port_base_addr;
  logic [7:0] wdata, rdata, fifo_threshold;
  logic [2:0] ext_ctl_mode;
  ppcu_opmode_t port_opmode;
  ppcu_protocol_t active_protocol;
  int bad_count, n_compared, cyc;
  ppcu_config_bank i_ppcu_config_bank (
    .clk             (clk),
    .resetn          (resetn),
    .power_on_resetn (power_on_resetn),
    .addr            (addr),
    .wdata           (wdata),
    .wr              (wr),
    .rd              (rd),
    .rdata           (rdata),
    .ext_ctl_mode    (ext_ctl_mode),
    .config_mode     (config_mode),
    .port_enable     (port_enable),
    .port_base_addr  (port_base_addr),
    .port_opmode     (port_opmode),
    .active_protocol (active_protocol),
    .fifo_threshold  (fifo_threshold)
  );
  initial forever #2 clk = ~clk;
  task automatic ck(logic [31:0] g, e);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %0t mismatch got %h exp %h", $time, g, e);
    end
  endtask
  task automatic w(logic [31:0] a, logic [7:0] d);
    @(posedge clk) {addr, wdata, wr} <= {a, d, 1'h1};
    @(posedge clk) wr <= 1'h0;
    #1;
  endtask
  task automatic rx(logic [7:0] i, e);
    w(SA, i);
    @(posedge clk) {addr, rd} <= {DA, 1'h1};
    @(posedge clk) rd <= 1'h0;
    #1 ck(rdata, e);
  endtask
  task automatic t1;
    w(SA, 8'h55);
    w(DA, 8'h00);
    w(SA, 8'h55);
    ck(config_mode, 1'h0);
    w(SA, 8'h55);
    rx(8'h0A, 8'h00);
    rx(8'h01, 8'h9F);
    w(DA, 8'h02);
    ck(port_base_addr, PPCU_BASE_ALT2);
    ck(port_opmode, PPCU_OP_STD);
    w(SA, 8'hAA);
    ck(config_mode, 1'h0);
    $display("t1 done");
  endtask
  task automatic t2;
    @(posedge clk) resetn <= 1'h0;
    @(posedge clk) resetn <= 1'h1;
    rx(8'h01, 8'h00);
    ck(port_opmode, PPCU_OP_STD);
    $display("t2 done");
  endtask
  // Back-to-back key pair, then the EPP, ECP, both and compatibility mode decodes
  task automatic t3;
    @(posedge clk) {addr, wdata, wr} <= {SA, PPCU_UNLOCK_KEY, 1'h1};
    @(posedge clk);
    @(posedge clk) wr <= 1'h0;
    #1 ck(config_mode, 1'h1);
    w(SA, PPCU_IDX_MODE);
    w(DA, 8'h03);
    ck(port_opmode, PPCU_OP_ECP_EPP);
    @(posedge clk) ext_ctl_mode <= PPCU_XCTL_EPP;
    #1 ck(active_protocol, PPCU_PROT_EPP);
    @(posedge clk) ext_ctl_mode <= PPCU_XCTL_STD;
    #1 ck(active_protocol, PPCU_PROT_STD);
    @(posedge clk) ext_ctl_mode <= 3'h1;
    #1 ck(active_protocol, PPCU_PROT_ECP);
    w(DA, 8'h01);
    ck(port_opmode, PPCU_OP_EPP_STD);
    ck(active_protocol, PPCU_PROT_EPP);
    w(DA, 8'h02);
    ck(port_opmode, PPCU_OP_ECP);
    w(SA, PPCU_IDX_BASE);
    w(DA, 8'h0B);
    ck(port_opmode, PPCU_OP_COMPAT);
    ck(port_base_addr, PPCU_BASE_DEFAULT);
    ck(port_enable, 1'h1);
    w(DA, 8'h08);
    ck(port_enable, 1'h0);
    ck(port_base_addr, PPCU_BASE_NONE);
    w(SA, PPCU_IDX_FIFO);
    w(DA, 8'h5A);
    ck(fifo_threshold, 8'h5A);
    rx(8'h04, 8'h02);
    rx(8'h02, 8'h00);
    w(SA, PPCU_EXIT_KEY);
    ck(config_mode, 1'h0);
    $display("t3 done");
  endtask
  task automatic end_sim;
    $display("%0d checks %0d bad", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Run needs about 65 cycles, so 500 means a hang
  always @(posedge clk) if (++cyc > 500) begin
    bad_count++;
    end_sim;
  end
  initial begin
    {resetn, power_on_resetn, wr, rd, addr, wdata, ext_ctl_mode} = '0;
    repeat (5) @(posedge clk);
    {resetn, power_on_resetn} <= 2'h3;
    t1;
    t2;
    t3;
    end_sim;
  end
endmodule
`default_nettype wire

/* File: ppcu_pkg.sv */
// Package for the parallel port configuration unlock bank
package ppcu_pkg;
  localparam logic [31:0] PPCU_SELECT_ADDR   = 32'h2200_07F0;
  localparam logic [31:0] PPCU_DATA_ADDR     = 32'h2200_07F1;
  localparam logic [7:0]  PPCU_UNLOCK_KEY    = 8'h55;
  localparam logic [7:0]  PPCU_EXIT_KEY      = 8'hAA;
  localparam logic [7:0]  PPCU_IDX_BASE      = 8'h01;
  localparam logic [7:0]  PPCU_IDX_MODE      = 8'h04;
  localparam logic [7:0]  PPCU_IDX_FIFO      = 8'h0A;
  localparam logic [7:0]  PPCU_BASE_RESET    = 8'h9F;
  localparam logic [7:0]  PPCU_MODE_RESET    = 8'h00;
  localparam logic [7:0]  PPCU_FIFO_RESET    = 8'h00;
  localparam logic [7:0]  PPCU_IDX_RESET     = 8'h00;
  localparam int          PPCU_COMPAT_BIT    = 3;
  localparam logic [31:0] PPCU_BASE_ALT1     = 32'h2200_0778;
  localparam logic [31:0] PPCU_BASE_ALT2     = 32'h2200_07BC;
  localparam logic [31:0] PPCU_BASE_DEFAULT  = 32'h2200_0678;
  localparam logic [31:0] PPCU_BASE_NONE     = 32'h0000_0000;
  localparam logic [2:0]  PPCU_XCTL_STD      = 3'h0;
  localparam logic [2:0]  PPCU_XCTL_EPP      = 3'h4;

  typedef enum logic [2:0] {
    PPCU_OP_COMPAT,
    PPCU_OP_STD,
    PPCU_OP_EPP_STD,
    PPCU_OP_ECP,
    PPCU_OP_ECP_EPP
  } ppcu_opmode_t;

  typedef enum logic [2:0] {
    PPCU_PROT_COMPAT,
    PPCU_PROT_STD,
    PPCU_PROT_EPP,
    PPCU_PROT_ECP
  } ppcu_protocol_t;
endpackage
